// ---- rtl/tfu_pkg.sv ----
// constants, carriers and state types for the timer interrupt flag unit
// assumes a single 100 MHz clock domain shared with the counter unit and the core
package tfu_pkg;

  localparam int unsigned TFU_REG_W = 8;
  localparam int unsigned TFU_ADDR_W = 4;
  localparam int unsigned TFU_DATA_W = 32;
  localparam int unsigned TFU_CNT_W = 16;
  localparam int unsigned TFU_NCMP = 3;

  // byte addresses of the register words
  localparam logic [3:0] TFU_OFS_FLAGS = 4'h0;
  localparam logic [3:0] TFU_OFS_MASK = 4'h4;
  localparam logic [3:0] TFU_OFS_CTRL = 4'h8;

  // field positions: the first five shared by the flag, mask and request vectors, the last in ctrl
  localparam int unsigned TFU_BIT_OVF = 0;
  localparam int unsigned TFU_BIT_CMP_A = 1;
  localparam int unsigned TFU_BIT_CMP_B = 2;
  localparam int unsigned TFU_BIT_CMP_C = 3;
  localparam int unsigned TFU_BIT_CAP = 5;
  localparam int unsigned TFU_CTRL_EDGE_BIT = 0;

  // bits 7, 6 and 4 are not implemented
  localparam logic [7:0] TFU_FLAG_IMPL = 8'h2F;
  localparam logic [7:0] TFU_FLAGS_RST = 8'h00;
  localparam logic [7:0] TFU_MASK_RST = 8'h00;
  localparam logic TFU_EDGE_RST = 1'b1;
  localparam logic [31:0] TFU_RDATA_ZERO = 32'h0000_0000;

  typedef enum logic [3:0] {
    TFU_WM_NORMAL = 4'h0,
    TFU_WM_PC8 = 4'h1,
    TFU_WM_PC9 = 4'h2,
    TFU_WM_PC10 = 4'h3,
    TFU_WM_CTC_CMPA = 4'h4,
    TFU_WM_FAST8 = 4'h5,
    TFU_WM_FAST9 = 4'h6,
    TFU_WM_FAST10 = 4'h7,
    TFU_WM_PFC_CAP = 4'h8,
    TFU_WM_PFC_CMPA = 4'h9,
    TFU_WM_PC_CAP = 4'hA,
    TFU_WM_PC_CMPA = 4'hB,
    TFU_WM_CTC_CAP = 4'hC,
    TFU_WM_RSVD = 4'hD,
    TFU_WM_FAST_CAP = 4'hE,
    TFU_WM_FAST_CMPA = 4'hF
  } tfu_wave_mode_t;

  // event pulses from the counter unit, one sys_clk cycle each
  typedef struct packed {
    logic tick;
    logic wrap_evt;
    logic top_evt;
    logic bottom_evt;
    logic cnt_write;
  } tfu_timer_evt_t;

  typedef struct packed {
    logic [TFU_CNT_W-1:0] counter_value;
    logic [TFU_CNT_W-1:0] cmp_a_value_reg;
    logic [TFU_CNT_W-1:0] cmp_b_value_reg;
    logic [TFU_CNT_W-1:0] cmp_c_value_reg;
  } tfu_cmp_vals_t;

  typedef struct packed {
    logic [TFU_REG_W-1:0] flags;
  } tfu_bank_state_t;

  typedef struct packed {
    logic [TFU_REG_W-1:0] mask;
    logic edge_rise;
    logic [1:0] cap_sync;
    logic cap_prev;
    logic [TFU_NCMP-1:0] match;
    logic block;
    logic ack;
    logic [TFU_DATA_W-1:0] rdata;
  } tfu_state_t;

endpackage

// ---- rtl/tfu_flag_bank.sv ----
// sticky flag bank: hardware set, clear by acknowledge or software one
// assumes set and clear vectors are same-clock pulses
`timescale 1ns/100ps
`default_nettype none

module tfu_flag_bank
  import tfu_pkg::*;
#(
  parameter logic [TFU_REG_W-1:0] IMPL = TFU_FLAG_IMPL,
  parameter logic [TFU_REG_W-1:0] RST_VAL = TFU_FLAGS_RST
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [TFU_REG_W-1:0] set_vec,
  input wire logic [TFU_REG_W-1:0] clr_vec,
  output logic [TFU_REG_W-1:0] flags
);

  tfu_bank_state_t st_q;
  tfu_bank_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.flags = ((st_q.flags & ~clr_vec) | set_vec) & IMPL;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q.flags <= RST_VAL;
    end else begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flags;

endmodule // tfu_flag_bank

`default_nettype wire

// ---- rtl/tfu_irq_flag_unit.sv ----
// interrupt flag, mask and request logic of a 16-bit timer with three
// compare channels, input capture and overflow, behind an Avalon-MM slave
// assumes the counter unit, the core and the bus share sys_clk; only the
// capture pin is asynchronous
//
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
`default_nettype none

//
// Overview of operation
// - compare A request needs enable, global, flag
// - overflow request needs enable, global, flag
// - mask bits 5,3,2 gate capture, C, B
// - flag bits 5,3,2,1,0; 7,6,4 read zero
// - capture pin edge sets capture flag
// - capture-as-top mode: top sets capture flag
// - compare flag sets one tick after match
// - overflow source chosen by waveform mode
// - vector execution clears its flag
// - writing one clears flag, zero keeps
module tfu_irq_flag_unit
  import tfu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [TFU_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [TFU_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [TFU_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire tfu_timer_evt_t timer_evt,
  input wire tfu_cmp_vals_t cmp_vals,
  input wire logic [3:0] waveform_mode_sel,
  input wire logic capture_input_pin,
  input wire logic global_irq_en,
  input wire logic [TFU_REG_W-1:0] vector_ack,
  output logic [TFU_REG_W-1:0] irq_req,
  output logic irq
);

  tfu_state_t st_q;
  tfu_state_t st_d;

  logic [TFU_REG_W-1:0] timer_flag_register;
  logic [TFU_REG_W-1:0] flag_set;
  logic [TFU_REG_W-1:0] flag_clr;
  logic [TFU_CNT_W-1:0] cmp_val [TFU_NCMP];
  logic [TFU_NCMP-1:0] cmp_hit;
  logic [TFU_NCMP-1:0] cmp_set;
  logic req_valid;
  logic wr_go;
  logic cap_edge;
  logic cap_top_set;
  logic ovf_set;
  logic cmp_a_flag;
  logic cmp_b_flag;
  logic cmp_c_flag;
  logic capture_flag;
  logic overflow_flag;
  logic cmp_a_irq_en;
  logic cmp_b_irq_en;
  logic cmp_c_irq_en;
  logic overflow_irq_en;
  logic capture_irq_en;

  // capture register acts as the counter top in these modes
  function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == TFU_WM_PFC_CAP) || (m == TFU_WM_PC_CAP) ||
                 (m == TFU_WM_CTC_CAP) || (m == TFU_WM_FAST_CAP);
  endfunction

  // non-PWM modes: overflow is the wrap of the counter
  function automatic logic mode_wraps(input logic [3:0] m);
    mode_wraps = (m == TFU_WM_NORMAL) || (m == TFU_WM_CTC_CMPA) ||
                 (m == TFU_WM_CTC_CAP) || (m == TFU_WM_RSVD);
  endfunction

  // single-slope PWM modes: overflow at top
  function automatic logic mode_fast(input logic [3:0] m);
    mode_fast = (m == TFU_WM_FAST8) || (m == TFU_WM_FAST9) ||
                (m == TFU_WM_FAST10) || (m == TFU_WM_FAST_CAP) ||
                (m == TFU_WM_FAST_CMPA);
  endfunction

  function automatic logic [TFU_REG_W-1:0] field_mask(input logic [TFU_REG_W-1:0] v);
    field_mask = v & TFU_FLAG_IMPL;
  endfunction

  assign cmp_val[0] = cmp_vals.cmp_a_value_reg;
  assign cmp_val[1] = cmp_vals.cmp_b_value_reg;
  assign cmp_val[2] = cmp_vals.cmp_c_value_reg;

  genvar gi;
  generate
    for (gi = 0; gi < TFU_NCMP; gi++) begin : g_cmp
      assign cmp_hit[gi] = (cmp_vals.counter_value == cmp_val[gi]);
      assign cmp_set[gi] = timer_evt.tick & st_q.match[gi];
    end
  endgenerate

  // one wait state per access, then the answer
  assign req_valid = avs_read | avs_write;
  assign avs_waitrequest = req_valid & ~st_q.ack;
  assign wr_go = avs_write & st_q.ack;

  // edge of the synchronised pin, polarity from ctrl
  assign cap_edge = st_q.edge_rise ? (st_q.cap_sync[1] & ~st_q.cap_prev)
                                   : (~st_q.cap_sync[1] & st_q.cap_prev);

  // top reached while capture register is top
  assign cap_top_set = cap_is_top(waveform_mode_sel) & timer_evt.top_evt;

  always_comb begin
    if (mode_wraps(waveform_mode_sel)) begin
      ovf_set = timer_evt.wrap_evt;
    end else if (mode_fast(waveform_mode_sel)) begin
      ovf_set = timer_evt.top_evt;
    end else begin
      ovf_set = timer_evt.bottom_evt;
    end
  end

  always_comb begin
    flag_set = '0;
    flag_set[TFU_BIT_OVF] = ovf_set;
    flag_set[TFU_BIT_CMP_A] = cmp_set[0];
    flag_set[TFU_BIT_CMP_B] = cmp_set[1];
    flag_set[TFU_BIT_CMP_C] = cmp_set[2];
    flag_set[TFU_BIT_CAP] = cap_edge | cap_top_set;
  end

  always_comb begin
    flag_clr = field_mask(vector_ack);
    if (wr_go && avs_address == TFU_OFS_FLAGS && avs_byteenable[0]) begin
      flag_clr = flag_clr | field_mask(avs_writedata[TFU_REG_W-1:0]);
    end
  end

  tfu_flag_bank #(
    .IMPL(TFU_FLAG_IMPL),
    .RST_VAL(TFU_FLAGS_RST)
  ) u_flags (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .set_vec(flag_set),
    .clr_vec(flag_clr),
    .flags(timer_flag_register)
  );

  always_comb begin
    st_d = st_q;
    // first stage is read only by the second
    st_d.cap_sync = {st_q.cap_sync[0], capture_input_pin};
    st_d.cap_prev = st_q.cap_sync[1];

    // a counter write suppresses the match seen at the next tick
    if (timer_evt.cnt_write) begin
      st_d.block = 1'b1;
    end else if (timer_evt.tick) begin
      st_d.block = 1'b0;
    end
    // sample match at a tick, flag at the next
    if (timer_evt.tick) begin
      st_d.match = cmp_hit & {TFU_NCMP{~st_q.block & ~timer_evt.cnt_write}};
    end

    // bus: answer in the cycle after the request is seen
    st_d.ack = req_valid & ~st_q.ack;
    st_d.rdata = TFU_RDATA_ZERO;
    if (avs_read && !st_q.ack) begin
      if (avs_address == TFU_OFS_FLAGS) begin
        st_d.rdata[TFU_REG_W-1:0] = field_mask(timer_flag_register);
      end else if (avs_address == TFU_OFS_MASK) begin
        st_d.rdata[TFU_REG_W-1:0] = st_q.mask;
      end else if (avs_address == TFU_OFS_CTRL) begin
        st_d.rdata[TFU_CTRL_EDGE_BIT] = st_q.edge_rise;
      end else begin
        st_d.rdata = TFU_RDATA_ZERO;
      end
    end
    if (wr_go && avs_byteenable[0]) begin
      if (avs_address == TFU_OFS_MASK) begin
        st_d.mask = field_mask(avs_writedata[TFU_REG_W-1:0]);
      end else if (avs_address == TFU_OFS_CTRL) begin
        st_d.edge_rise = avs_writedata[TFU_CTRL_EDGE_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q.mask <= TFU_MASK_RST;
      st_q.edge_rise <= TFU_EDGE_RST;
      st_q.cap_sync <= 2'h0;
      st_q.cap_prev <= 1'b0;
      st_q.match <= '0;
      st_q.block <= 1'b0;
      st_q.ack <= 1'b0;
      st_q.rdata <= TFU_RDATA_ZERO;
    end else begin
      st_q <= st_d;
    end
  end

  assign cmp_a_flag = timer_flag_register[TFU_BIT_CMP_A];
  assign cmp_b_flag = timer_flag_register[TFU_BIT_CMP_B];
  assign cmp_c_flag = timer_flag_register[TFU_BIT_CMP_C];
  assign capture_flag = timer_flag_register[TFU_BIT_CAP];
  assign overflow_flag = timer_flag_register[TFU_BIT_OVF];
  assign cmp_a_irq_en = st_q.mask[TFU_BIT_CMP_A];
  assign cmp_b_irq_en = st_q.mask[TFU_BIT_CMP_B];
  assign cmp_c_irq_en = st_q.mask[TFU_BIT_CMP_C];
  assign overflow_irq_en = st_q.mask[TFU_BIT_OVF];
  assign capture_irq_en = st_q.mask[TFU_BIT_CAP];

  // requests are combinational so an acknowledge drops them next cycle
  always_comb begin
    irq_req = '0;
    irq_req[TFU_BIT_CMP_A] = cmp_a_flag & cmp_a_irq_en & global_irq_en;
    irq_req[TFU_BIT_OVF] = overflow_flag & overflow_irq_en & global_irq_en;
    irq_req[TFU_BIT_CAP] = capture_flag & capture_irq_en & global_irq_en;
    irq_req[TFU_BIT_CMP_C] = cmp_c_flag & cmp_c_irq_en & global_irq_en;
    irq_req[TFU_BIT_CMP_B] = cmp_b_flag & cmp_b_irq_en & global_irq_en;
  end

  assign irq = |irq_req;
  assign avs_readdata = st_q.rdata;

endmodule // tfu_irq_flag_unit

`default_nettype wire

// ---- dv/tfu_irq_flag_unit_assertions.sv ----
// checker for the timer interrupt flag unit, bound to its top module
// assumes one clock domain and the active-low asynchronous reset
`timescale 1ns/100ps
`default_nettype none
module tfu_irq_flag_unit_chk
  import tfu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [TFU_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [TFU_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [TFU_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire tfu_timer_evt_t timer_evt,
  input wire logic global_irq_en,
  input wire logic [TFU_REG_W-1:0] vector_ack,
  input wire logic [TFU_REG_W-1:0] irq_req,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_req_needs_global: assert property (|irq_req |-> global_irq_en)
    else $error("request while interrupts globally off");
  a_irq_is_or: assert property (irq == (|irq_req))
    else $error("irq differs from or of requests");
  a_rsvd_req_zero: assert property (irq_req[7:6] == 2'h0 && !irq_req[4])
    else $error("request on unimplemented bit");
  a_ack_clears_ovf: assert property (vector_ack[0] && timer_evt == '0 |=> !irq_req[0])
    else $error("overflow request survives acknowledge");
  a_wone_clears_cmp: assert property (avs_write && !avs_waitrequest && avs_address == TFU_OFS_FLAGS
    && avs_byteenable[0] && avs_writedata[1] && !timer_evt.tick |=> !irq_req[1])
    else $error("compare A request survives write of one");
  a_cmp_rise_cause: assert property ($rose(irq_req[1]) |-> $past(timer_evt.tick)
    || $past(avs_write) || $rose(global_irq_en)) else $error("compare A request rose without tick");
  a_bus_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait");
  a_flag_rdata_bits: assert property (avs_read && !avs_waitrequest && avs_address == TFU_OFS_FLAGS
    |-> avs_readdata[31:6] == 26'h0 && !avs_readdata[4]) else $error("flag read sets reserved bits");
  a_rdata_idle_zero: assert property (!(avs_read && !avs_waitrequest) |-> avs_readdata == TFU_RDATA_ZERO)
    else $error("read data outside answer cycle");
  c_ack: cover property (vector_ack[0] ##1 !irq_req[0]);
  c_irq_rise: cover property ($rose(irq));
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule // tfu_irq_flag_unit_chk
bind tfu_irq_flag_unit tfu_irq_flag_unit_chk u_tfu_irq_flag_unit_chk (.sys_clk(sys_clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .timer_evt(timer_evt), .global_irq_en(global_irq_en), .vector_ack(vector_ack), .irq_req(irq_req), .irq(irq));
`default_nettype wire

// ---- dv/tfu_core_model.sv ----
// core model: takes the lowest pending request and acknowledges its vector
// assumes requests are levels on sys_clk; dly sets how slowly it answers
`timescale 1ns/100ps
`default_nettype none
module tfu_core_model
  import tfu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] dly,
  input wire logic [TFU_REG_W-1:0] irq_req,
  output logic [TFU_REG_W-1:0] vector_ack
);
  logic [3:0] cnt_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      vector_ack <= 8'h00;
    end else begin
      vector_ack <= 8'h00;
      // wait while the last acknowledge lands, or it would be sent twice
      if (irq_req == 8'h00 || vector_ack != 8'h00) begin
        cnt_q <= 4'h0;
      end else if (cnt_q >= dly) begin
        vector_ack <= irq_req & (~irq_req + 8'h01);
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule // tfu_core_model
`default_nettype wire

// ---- dv/tb_tfu_irq_flag_unit.sv ----
// testbench: register reads and writes plus timer events, checked against expectations
// assumes an Avalon-MM slave with waitrequest; the master waits for the answer, bounded by a timeout
`timescale 1ns/100ps
`default_nettype none
module tb_tfu_irq_flag_unit;
  import tfu_pkg::*;
  logic sys_clk, rstn, avs_read, avs_write, avs_waitrequest, pin, glob, irq;
  logic [3:0] addr, dly, wmode;
  logic [31:0] wdata, rdata, q;
  logic [7:0] tb_ack, core_ack, irq_req;
  tfu_timer_evt_t evt;
  tfu_cmp_vals_t cv;
  int n_mismatch = 0;
  int checks_done = 0;
  tfu_irq_flag_unit u_tfu_irq_flag_unit (.sys_clk(sys_clk), .rstn(rstn), .avs_address(addr), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
    .avs_waitrequest(avs_waitrequest), .timer_evt(evt), .cmp_vals(cv), .waveform_mode_sel(wmode),
    .capture_input_pin(pin), .global_irq_en(glob), .vector_ack(tb_ack | core_ack), .irq_req(irq_req), .irq(irq));
  tfu_core_model u_tfu_core_model (.sys_clk(sys_clk), .rstn(rstn), .dly(dly), .irq_req(irq_req),
    .vector_ack(core_ack));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // the answer is taken at the rising edge where waitrequest is seen low
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) chk("waitrequest", 32'h1, 32'h0);
    q = rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic pulse(input logic [4:0] e);
    evt <= tfu_timer_evt_t'(e);
    @(posedge sys_clk);
    evt <= tfu_timer_evt_t'(5'h00);
    @(posedge sys_clk);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    int w;
    {rstn, avs_read, avs_write, pin, glob, addr, wdata, tb_ack, evt} = '0;
    dly = 4'hF;
    wmode = 4'h0;
    cv = {16'h0005, 16'h0005, 16'h0005, 16'h0005};
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rd(TFU_OFS_FLAGS, 32'h0, "flags reset");
    rd(TFU_OFS_MASK, 32'h0, "mask reset");
    bus(1'b1, TFU_OFS_MASK, 32'hFF);
    rd(TFU_OFS_MASK, 32'h2F, "mask bits");
    rd(4'hC, 32'h0, "unmapped");
    rd(TFU_OFS_CTRL, 32'h1, "ctrl reset");
    for (int m = 0; m < 16; m++) for (int e = 0; e < 3; e++) begin
      wmode <= m[3:0];
      pulse(5'h08 >> e);
      w = (m inside {0, 4, 12, 13}) ? 0 : (m inside {5, 6, 7, 14, 15}) ? 1 : 2;
      rd(TFU_OFS_FLAGS, {26'h0, e == 1 && m inside {8, 10, 12, 14}, 4'h0, w == e}, "mode flags");
      bus(1'b1, TFU_OFS_FLAGS, 32'hFF);
    end
    wmode <= 4'h0;
    pulse(5'h10);
    rd(TFU_OFS_FLAGS, 32'h0, "one tick");
    pulse(5'h10);
    rd(TFU_OFS_FLAGS, 32'h0E, "cmp flags");
    bus(1'b1, TFU_OFS_FLAGS, 32'hFF);
    // the match latched at the earlier tick still sets the flags here
    pulse(5'h11);
    rd(TFU_OFS_FLAGS, 32'h0E, "match before write");
    bus(1'b1, TFU_OFS_FLAGS, 32'hFF);
    // the blocked tick latches no match, so the next tick sets nothing
    pulse(5'h10);
    pulse(5'h10);
    rd(TFU_OFS_FLAGS, 32'h0, "blocked");
    pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(TFU_OFS_FLAGS, 32'h20, "capture");
    bus(1'b1, TFU_OFS_FLAGS, 32'hFF);
    bus(1'b1, TFU_OFS_CTRL, 32'h0);
    rd(TFU_OFS_CTRL, 32'h0, "ctrl falling");
    pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd(TFU_OFS_FLAGS, 32'h20, "capture fall");
    bus(1'b1, TFU_OFS_FLAGS, 32'hFF);
    tb_ack <= 8'h01;
    evt <= tfu_timer_evt_t'(5'h08);
    @(posedge sys_clk);
    tb_ack <= 8'h00;
    evt <= tfu_timer_evt_t'(5'h00);
    @(posedge sys_clk);
    rd(TFU_OFS_FLAGS, 32'h01, "set wins");
    bus(1'b1, TFU_OFS_MASK, 32'h01);
    chk("irq_req off", irq_req, 8'h00);
    bus(1'b1, TFU_OFS_FLAGS, 32'h00);
    rd(TFU_OFS_FLAGS, 32'h01, "write zero");
    glob <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("irq_req ovf", {irq, irq_req}, 9'h101);
    repeat (20) @(posedge sys_clk);
    rd(TFU_OFS_FLAGS, 32'h0, "acked slow");
    dly <= 4'h0;
    glob <= 1'b0;
    bus(1'b1, TFU_OFS_MASK, 32'h02);
    pulse(5'h10);
    pulse(5'h10);
    @(negedge sys_clk);
    chk("irq_req no global", irq_req, 8'h00);
    @(posedge sys_clk);
    glob <= 1'b1;
    @(negedge sys_clk);
    chk("irq_req cmp a", irq_req, 8'h02);
    repeat (4) @(posedge sys_clk);
    // only compare A is unmasked, so B and C stay pending
    rd(TFU_OFS_FLAGS, 32'h0C, "acked prompt");
    finish_test();
  end
endmodule // tb_tfu_irq_flag_unit
`default_nettype wire
